// File: rtl/spcgd_defs.vh
// Purpose: constants for the two-channel pulse counter and Gray decoder
// Assumes: one 50 MHz clock, APB register access, 32-bit data
// Notes:   the channel stride is a byte address, register offsets are word indices
//
// Behaviour
// - Two channels, mode chosen per channel independently
// - Pulse mode steps count by one per falling edge
// - Count starts at zero after reset
// - Count is 24 bits, 0 to 16777215
// - Without external direction, program bit sets direction
// - External direction: low counts up, high down
// - Gate low counts, high clears and holds count at zero
// - Release false clears count, true lets it count
// - One level select per channel, all inputs
// - Decoder mode ignores direction and release settings
// - Decoder bits: pulse, direction, gate, fourth input
// - Four-bit code on fast variant, else three
// - Gray pattern reported unchanged as binary value
// - Three copies compared, mismatch discards and flags error; code counts it a mismatch only when two copies differ in more than one bit
// - Passing comparison loads value into reading
// - Fourth input unused in pulse mode
`ifndef SPCGD_DEFS_VH
`define SPCGD_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SPCGD_CH_STRIDE      8'h10
`define SPCGD_OFF_CTRL       2'h0
`define SPCGD_OFF_READ       2'h1
`define SPCGD_OFF_STAT       2'h2

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SPCGD_CTRL_LEVEL     0
`define SPCGD_CTRL_EXTDIR    1
`define SPCGD_CTRL_DOWN      2
`define SPCGD_CTRL_DECODER   3
`define SPCGD_CTRL_RELEASE   4
`define SPCGD_CTRL_W         5
`define SPCGD_CTRL_RST       5'h00
`define SPCGD_STAT_ERR       0

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SPCGD_CNT_W          24
`define SPCGD_CNT_RST        24'h000000
`define SPCGD_CODE_W         4

`endif

// File: rtl/spcgd_top.v
// Purpose: two high-speed counter channels with Gray-code decoder mode
// Assumes: APB slave, zero wait states; pins asynchronous to CLK
// Notes:   input thresholds live in the analogue front end, steered
//          by the INPUT_LEVEL_SELECT outputs
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "spcgd_defs.vh"

module spcgd_top #(
  parameter WIDE_GRAY = 1
) (
  input  wire        CLK,
  input  wire        RST_B,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        PULSE_IN_CH0,
  input  wire        PULSE_IN_CH1,
  input  wire        DIR_IN_CH0,
  input  wire        DIR_IN_CH1,
  input  wire        GATE_CLEAR_IN_CH0,
  input  wire        GATE_CLEAR_IN_CH1,
  input  wire        FOURTH_IN_CH0,
  input  wire        FOURTH_IN_CH1,
  output wire        INPUT_LEVEL_SELECT_CH0,
  output wire        INPUT_LEVEL_SELECT_CH1,
  output wire [23:0] COUNTER_READING_CH0,
  output wire [23:0] COUNTER_READING_CH1,
  output wire        CHANNEL_ERROR_STATUS_CH0,
  output wire        CHANNEL_ERROR_STATUS_CH1
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       addr_hit;
  wire       ch_sel;
  wire [1:0] reg_sel;
  wire       wr_acc;
  wire       rd_setup;

  // Address bits 1:0 are ignored: each register is one whole word
  assign ch_sel   = PADDR[4];
  assign reg_sel  = PADDR[3:2];
  assign addr_hit = (PADDR[7:5] == 3'h0) && (reg_sel != 2'h3);
  assign wr_acc   = PSEL & PENABLE & PWRITE & addr_hit;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

  // Zero wait states; read data is captured in the setup cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_hit;

  // ----------------------------------------------------------------
  // Packed pin groups
  // ----------------------------------------------------------------
  wire [1:0] pin_pulse;
  wire [1:0] pin_dir;
  wire [1:0] pin_gate;
  wire [1:0] pin_fourth;

  assign pin_pulse  = {PULSE_IN_CH1, PULSE_IN_CH0};
  assign pin_dir    = {DIR_IN_CH1, DIR_IN_CH0};
  assign pin_gate   = {GATE_CLEAR_IN_CH1, GATE_CLEAR_IN_CH0};
  assign pin_fourth = {FOURTH_IN_CH1, FOURTH_IN_CH0};

  wire [2*`SPCGD_CTRL_W-1:0] ctrl_all;
  wire [2*`SPCGD_CNT_W-1:0]  cnt_all;
  wire [1:0]                 err_all;

  // ----------------------------------------------------------------
  // Hamming distance above one
  // ----------------------------------------------------------------
  // Counts the bits in which two copies of the pattern differ
  function spcgd_far;
    input [`SPCGD_CODE_W-1:0] a;
    input [`SPCGD_CODE_W-1:0] b;
    reg   [`SPCGD_CODE_W-1:0] x;
    reg   [2:0]               n;
    integer                   k;
    begin
      x = a ^ b;
      n = 3'h0;
      for (k = 0; k < `SPCGD_CODE_W; k = k + 1) begin
        n = n + {2'h0, x[k]};
      end
      spcgd_far = (n > 3'h1);
    end
  endfunction

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar c;
  genvar t;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      reg  [3:0]                sync1_q;
      reg  [3:0]                sync2_q;
      reg                       pulse_prev_q;
      reg  [`SPCGD_CTRL_W-1:0]  ctrl_q;
      reg  [`SPCGD_CNT_W-1:0]   cnt_q;
      reg  [`SPCGD_CNT_W-1:0]   cnt_d;
      reg                       err_q;
      wire [3*`SPCGD_CODE_W-1:0] trip_all;
      wire [`SPCGD_CODE_W-1:0]  trip0;
      wire [`SPCGD_CODE_W-1:0]  trip1;
      wire [`SPCGD_CODE_W-1:0]  trip2;
      wire                      s_pulse;
      wire                      s_dir;
      wire                      s_gate;
      wire                      s_fourth;
      wire                      fall;
      wire                      down;
      wire                      dec_mode;
      wire                      release_on;
      wire [`SPCGD_CODE_W-1:0]  code;
      wire [`SPCGD_CODE_W-1:0]  vote;
      wire                      mismatch;
      wire                      ctrl_we;
      wire                      stat_we;

      // Channel number as one bit keeps the select compare 1 bit wide
      localparam CH_BIT = (c == 1) ? 1'b1 : 1'b0;

      // Pins are asynchronous: two flops before any use
      always @(posedge CLK) begin
        if (!RST_B) begin
          sync1_q <= 4'h0;
          sync2_q <= 4'h0;
        end else begin
          sync1_q <= {pin_fourth[c], pin_gate[c], pin_dir[c],
                      pin_pulse[c]};
          sync2_q <= sync1_q;
        end
      end

      assign s_pulse  = sync2_q[0];
      assign s_dir    = sync2_q[1];
      assign s_gate   = sync2_q[2];
      // The fourth input feeds the decoder pattern and nothing else
      assign s_fourth = sync2_q[3];

      // Resets low like the idle pin, so reset never fakes an edge
      always @(posedge CLK) begin
        if (!RST_B) begin
          pulse_prev_q <= 1'b0;
        end else begin
          pulse_prev_q <= s_pulse;
        end
      end

      assign fall = pulse_prev_q & ~s_pulse;

      // Control register
      assign ctrl_we = wr_acc && (ch_sel == CH_BIT) &&
                       (reg_sel == `SPCGD_OFF_CTRL);
      assign stat_we = wr_acc && (ch_sel == CH_BIT) &&
                       (reg_sel == `SPCGD_OFF_STAT);

      always @(posedge CLK) begin
        if (!RST_B) begin
          ctrl_q <= `SPCGD_CTRL_RST;
        end else if (ctrl_we) begin
          ctrl_q <= PWDATA[`SPCGD_CTRL_W-1:0];
        end
      end

      assign dec_mode   = ctrl_q[`SPCGD_CTRL_DECODER];
      assign release_on = ctrl_q[`SPCGD_CTRL_RELEASE];
      assign down = ctrl_q[`SPCGD_CTRL_EXTDIR] ? s_dir :
                    ctrl_q[`SPCGD_CTRL_DOWN];

      // Decoder input pattern; bit 3 only on the wide variant
      assign code = {(WIDE_GRAY != 0) ? s_fourth : 1'b0,
                     s_gate, s_dir, s_pulse};

      // Three redundant samplers of the same pattern, one flop group each
      for (t = 0; t < 3; t = t + 1) begin : g_trip
        reg [`SPCGD_CODE_W-1:0] trip_q;

        always @(posedge CLK) begin
          if (!RST_B) begin
            trip_q <= {`SPCGD_CODE_W{1'b0}};
          end else begin
            trip_q <= code;
          end
        end

        assign trip_all[t*`SPCGD_CODE_W +: `SPCGD_CODE_W] = trip_q;
      end

      assign trip0 = trip_all[`SPCGD_CODE_W-1:0];
      assign trip1 = trip_all[2*`SPCGD_CODE_W-1:`SPCGD_CODE_W];
      assign trip2 = trip_all[3*`SPCGD_CODE_W-1:2*`SPCGD_CODE_W];

      assign vote = (trip0 & trip1) | (trip0 & trip2) |
                    (trip1 & trip2);
      // Copies share one synced source, so a mismatch means a fault
      assign mismatch = spcgd_far(trip0, trip1) |
                        spcgd_far(trip0, trip2) |
                        spcgd_far(trip1, trip2);

      // Next count; 24-bit arithmetic wraps on its own
      // Synced gate high holds zero: a short pulse clears, a long one halts
      always @* begin
        cnt_d = cnt_q;
        if (dec_mode) begin
          if (!mismatch) begin
            cnt_d = {20'h00000, vote};
          end
        end else if (!release_on) begin
          cnt_d = `SPCGD_CNT_RST;
        end else if (s_gate) begin
          cnt_d = `SPCGD_CNT_RST;
        end else if (fall) begin
          if (down) begin
            cnt_d = cnt_q - 24'h000001;
          end else begin
            cnt_d = cnt_q + 24'h000001;
          end
        end
      end

      always @(posedge CLK) begin
        if (!RST_B) begin
          cnt_q <= `SPCGD_CNT_RST;
        end else begin
          cnt_q <= cnt_d;
        end
      end

      // Sticky error; a new mismatch beats a clear in the same cycle
      always @(posedge CLK) begin
        if (!RST_B) begin
          err_q <= 1'b0;
        end else if (dec_mode && mismatch) begin
          err_q <= 1'b1;
        end else if (stat_we && PWDATA[`SPCGD_STAT_ERR]) begin
          err_q <= 1'b0;
        end
      end

      assign ctrl_all[c*`SPCGD_CTRL_W +: `SPCGD_CTRL_W] = ctrl_q;
      assign cnt_all[c*`SPCGD_CNT_W +: `SPCGD_CNT_W]    = cnt_q;
      assign err_all[c]                                  = err_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    case (reg_sel)
      `SPCGD_OFF_CTRL: begin
        rd_d = {27'h0000000,
                ctrl_all[ch_sel*`SPCGD_CTRL_W +: `SPCGD_CTRL_W]};
      end
      `SPCGD_OFF_READ: begin
        rd_d = {8'h00, cnt_all[ch_sel*`SPCGD_CNT_W +: `SPCGD_CNT_W]};
      end
      `SPCGD_OFF_STAT: begin
        rd_d = {31'h00000000, err_all[ch_sel]};
      end
      default: begin
        rd_d = 32'h00000000;
      end
    endcase
    // Unmapped addresses read as zero
    if (!addr_hit) begin
      rd_d = 32'h00000000;
    end
  end

  // Held until the next read setup, so the access phase sees a flop
  always @(posedge CLK) begin
    if (!RST_B) begin
      PRDATA <= 32'h00000000;
    end else if (rd_setup) begin
      PRDATA <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // One select per channel steers the threshold of all its inputs
  assign INPUT_LEVEL_SELECT_CH0 = ctrl_all[`SPCGD_CTRL_LEVEL];
  assign INPUT_LEVEL_SELECT_CH1 =
         ctrl_all[`SPCGD_CTRL_W + `SPCGD_CTRL_LEVEL];
  // Readings and error flags come straight from their flops
  assign COUNTER_READING_CH0      = cnt_all[`SPCGD_CNT_W-1:0];
  assign COUNTER_READING_CH1      = cnt_all[2*`SPCGD_CNT_W-1:`SPCGD_CNT_W];
  assign CHANNEL_ERROR_STATUS_CH0 = err_all[0];
  assign CHANNEL_ERROR_STATUS_CH1 = err_all[1];

endmodule // spcgd_top

// File: sim/spcgd_checker.sv
// Purpose: port assertions for the counter and decoder block
// Assumes: channel 0 runs in pulse mode during the run
// Notes:   control bits are mirrored from APB writes, not peeked
`timescale 1ns/1ns
module spcgd_checker (
  input wire        CLK,
  input wire        RST_B,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        PULSE_IN_CH0,
  input wire        DIR_IN_CH0,
  input wire        GATE_CLEAR_IN_CH0,
  input wire        INPUT_LEVEL_SELECT_CH0,
  input wire [23:0] COUNTER_READING_CH0,
  input wire        CHANNEL_ERROR_STATUS_CH0
);
  reg  [4:0]  c0_q;
  wire        wr = PSEL && PENABLE && PWRITE;
  wire        bad = (PADDR[7:5] != 3'h0) || (PADDR[3:2] == 2'h3);
  wire        cnt0 = c0_q[4] && !c0_q[3] && !GATE_CLEAR_IN_CH0;
  // Raw pin used: the bench holds direction long before each edge
  wire        dn0 = c0_q[1] ? DIR_IN_CH0 : c0_q[2];
  wire [23:0] stp0 = dn0 ? 24'hFFFFFF : 24'h000001;
  always @(posedge CLK)
    if (!RST_B) c0_q <= 5'h00;
    else if (wr && PADDR == 8'h00) c0_q <= PWDATA[4:0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_slverr;
    PREADY && (PSLVERR == (PSEL && PENABLE && bad));
  endproperty
  a_slverr: assert property (p_slverr) else $error("apb answer wrong");
  property p_rst;
    $rose(RST_B) |-> COUNTER_READING_CH0 == 24'h000000
      && !CHANNEL_ERROR_STATUS_CH0 && !INPUT_LEVEL_SELECT_CH0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  // Sync delay puts the update two to five edges after the pin falls
  property p_step;
    cnt0 && $fell(PULSE_IN_CH0) |-> ##[2:5]
      (COUNTER_READING_CH0 - $past(COUNTER_READING_CH0) == stp0);
  endproperty
  a_step: assert property (p_step) else $error("step");
  property p_hold;
    (cnt0 && !$fell(PULSE_IN_CH0))[*8] |-> $stable(COUNTER_READING_CH0);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_gate;
    (GATE_CLEAR_IN_CH0 && !c0_q[3])[*5] |-> COUNTER_READING_CH0 == 24'h000000;
  endproperty
  a_gate: assert property (p_gate) else $error("gate clear");
  property p_rel;
    (!c0_q[4] && !c0_q[3])[*3] |-> COUNTER_READING_CH0 == 24'h000000;
  endproperty
  a_rel: assert property (p_rel) else $error("release clear");
  property p_level;
    INPUT_LEVEL_SELECT_CH0 == c0_q[0];
  endproperty
  a_level: assert property (p_level) else $error("level select");
  property p_rdback;
    PSEL && !PENABLE && !PWRITE && PADDR == 8'h04 |=>
      PRDATA == {8'h00, $past(COUNTER_READING_CH0)};
  endproperty
  a_rdback: assert property (p_rdback) else $error("reading word");
endmodule // spcgd_checker
bind spcgd_top spcgd_checker u_chk (.*);

// File: sim/spcgd_src.sv
// Purpose: pulse and pattern source on the channel pins
// Assumes: drive is called right after a rising edge
// Notes:   pattern is {fourth, gate, direction, pulse}
`timescale 1ns/1ns
module spcgd_src #(
  parameter HALF = 25
) (
  input  wire       clk,
  output reg  [3:0] pin0_q,
  output reg  [3:0] pin1_q
);
  initial pin0_q = 4'h0;
  initial pin1_q = 4'h0;
  // Each level stands HALF cycles, so edges never exceed the rate limit
  task drive(input int ch, input logic [3:0] v);
    if (ch == 0) pin0_q <= v;
    else pin1_q <= v;
    repeat (HALF) @(posedge clk);
  endtask
endmodule // spcgd_src

// File: sim/spcgd_top_tb.sv
// Purpose: self-checking bench for the counter and decoder block
// Assumes: zero wait APB slave, pins from the source model
// Notes:   read results are queued and checked by the monitor
`timescale 1ns/1ns
module spcgd_top_tb;
  logic        CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000, seed = 32'h0000D7E1;
  logic [32:0] exp_q[$], e;
  logic [3:0]  g;
  logic [23:0] pv, pe;
  int          err_count = 0, n_compared = 0, i;
  wire  [31:0] PRDATA;
  wire  [23:0] COUNTER_READING_CH0, COUNTER_READING_CH1;
  wire  [3:0]  pin0, pin1;
  wire         PREADY, PSLVERR, INPUT_LEVEL_SELECT_CH0, INPUT_LEVEL_SELECT_CH1;
  wire         CHANNEL_ERROR_STATUS_CH0, CHANNEL_ERROR_STATUS_CH1;
  wire         FOURTH_IN_CH0, GATE_CLEAR_IN_CH0, DIR_IN_CH0, PULSE_IN_CH0;
  wire         FOURTH_IN_CH1, GATE_CLEAR_IN_CH1, DIR_IN_CH1, PULSE_IN_CH1;
  assign {FOURTH_IN_CH0, GATE_CLEAR_IN_CH0, DIR_IN_CH0, PULSE_IN_CH0} = pin0;
  assign {FOURTH_IN_CH1, GATE_CLEAR_IN_CH1, DIR_IN_CH1, PULSE_IN_CH1} = pin1;
  spcgd_top u_dut (.*);
  spcgd_src u_src (.clk(CLK), .pin0_q(pin0), .pin1_q(pin1));
  initial forever #10 CLK = ~CLK;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Idle edge after each transfer keeps one assignment per time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] x);
    if (!w) exp_q.push_back(x);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h000000000);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] x);
    apb(1'b0, a, 32'h00000000, x);
  endtask
  // Fourth input toggles at random; it must not disturb the count
  task pulses(input int n, input logic [1:0] gd);
    repeat (n) begin
      seed = xs(seed);
      u_src.drive(0, {seed[0], gd, 1'b1});
      u_src.drive(0, {seed[1], gd, 1'b0});
    end
  endtask
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
      e = exp_q.pop_front();
      n_compared++;
      if ({PSLVERR, PRDATA} !== e) begin
        $display("BAD prdata exp %h got %h", e, {PSLVERR, PRDATA});
        err_count++;
      end
      // Pin outputs must agree with the register word just read
      if (PADDR[3:2] == 2'h1) begin
        pv = PADDR[4] ? COUNTER_READING_CH1 : COUNTER_READING_CH0;
        pe = e[23:0];
      end else if (PADDR[3:2] == 2'h2) begin
        pv = {23'h000000, PADDR[4] ? CHANNEL_ERROR_STATUS_CH1
                                   : CHANNEL_ERROR_STATUS_CH0};
        pe = {23'h000000, e[0]};
      end else begin
        pv = {23'h000000, PADDR[4] ? INPUT_LEVEL_SELECT_CH1
                                   : INPUT_LEVEL_SELECT_CH0};
        pe = {23'h000000, e[0]};
      end
      if (!e[32]) begin
        n_compared++;
        if (pv !== pe) begin
          $display("BAD pins exp %h got %h", pe, pv);
          err_count++;
        end
      end
    end
  end
  initial begin
    repeat (30000) @(posedge CLK);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd(8'h00, 33'h000000000);
    rd(8'h04, 33'h000000000);
    rd(8'h18, 33'h000000000);
    rd(8'h0C, 33'h100000000);
    wr(8'h20, 32'h00000010);
    rd(8'h20, 33'h100000000);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 33'h000000000);
    wr(8'h00, 32'h00000011);
    rd(8'h00, 33'h000000011);
    wr(8'h10, 32'h0000000F);
    rd(8'h10, 33'h00000000F);
    pulses(5, 2'b00);
    rd(8'h04, 33'h000000005);
    wr(8'h00, 32'h00000014);
    pulses(7, 2'b00);
    rd(8'h04, 33'h000FFFFFE);
    wr(8'h00, 32'h00000012);
    pulses(2, 2'b01);
    rd(8'h04, 33'h000FFFFFC);
    pulses(5, 2'b00);
    rd(8'h04, 33'h000000001);
    pulses(2, 2'b10);
    rd(8'h04, 33'h000000000);
    pulses(3, 2'b00);
    u_src.drive(0, 4'h4);
    u_src.drive(0, 4'h0);
    rd(8'h04, 33'h000000000);
    wr(8'h00, 32'h00000002);
    pulses(2, 2'b00);
    rd(8'h04, 33'h000000000);
    for (i = 0; i < 22; i++) begin
      seed = xs(seed);
      g = (i < 16) ? (i[3:0] ^ i[4:1]) : seed[3:0];
      u_src.drive(1, g);
      rd(8'h14, {29'h0000000, g});
    end
    rd(8'h08, 33'h000000000);
    wr(8'h18, 32'h00000001);
    rd(8'h18, 33'h000000000);
    finish_test();
  end
endmodule // spcgd_top_tb
